/* logic/sleep_pkg.sv */
// constants and state type for the sleep/transmit pin controller
//
// Overview of operation
// - rising pin edge starts a frame in synth-ready, a retry in auto-retry state
// - transmit triggers react to rising edges only, never to falls or levels
// - rising edge in busy auto-ack receive with slotted mode starts the ack
// - rising edge in radio idle enters sleep and stops the clock output
// - rising edge in deep-sleep prep enters deep sleep and stops clock output
// - low pin level in sleep or deep sleep returns to radio idle
// - device stays asleep while pin high, returns to radio idle on the fall
// - fast clock output keeps running 35 more cycles after sleep entry
// - slow clock output settings stop at once on sleep entry
// - leaving deep sleep resets the clock output rate to 1 MHz
// - register contents are held cleared while in deep sleep
// - reaching radio idle from reset, sleep or deep sleep raises wake-done
package sleep_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned F_1M_HZ      = 1_000_000;
  localparam int unsigned F_2M_HZ      = 2_000_000;
  localparam int unsigned F_4M_HZ      = 4_000_000;
  localparam int unsigned F_250K_HZ    = 250_000;
  localparam int unsigned F_62K5_HZ    = 62_500;
  localparam int unsigned DRAIN_CYCLES = 35;
  localparam int unsigned DIV_W        = 9;
  localparam int unsigned RATE_W       = 3;

  localparam logic [RATE_W-1:0] RATE_OFF   = 3'h0;
  localparam logic [RATE_W-1:0] RATE_1M    = 3'h1;
  localparam logic [RATE_W-1:0] RATE_2M    = 3'h2;
  localparam logic [RATE_W-1:0] RATE_4M    = 3'h3;
  localparam logic [RATE_W-1:0] RATE_250K  = 3'h4;
  localparam logic [RATE_W-1:0] RATE_62K5  = 3'h5;
  localparam logic [RATE_W-1:0] RATE_RESET = RATE_1M;

  localparam logic [DIV_W-1:0] HALF_1M   = DIV_W'(CLK_HZ / (2 * F_1M_HZ));
  localparam logic [DIV_W-1:0] HALF_2M   = DIV_W'(CLK_HZ / (2 * F_2M_HZ));
  localparam logic [DIV_W-1:0] HALF_4M   = DIV_W'(CLK_HZ / (2 * F_4M_HZ));
  localparam logic [DIV_W-1:0] HALF_250K = DIV_W'(CLK_HZ / (2 * F_250K_HZ));
  localparam logic [DIV_W-1:0] HALF_62K5 = DIV_W'(CLK_HZ / (2 * F_62K5_HZ));
  localparam logic [5:0]       DRAIN_RELOAD = 6'(DRAIN_CYCLES);

  typedef enum logic [7:0] {
    st_other       = 8'h01,
    st_idle        = 8'h02,
    st_synth_ready = 8'h04,
    st_auto_retry  = 8'h08,
    st_busy_aack   = 8'h10,
    st_deep_prep   = 8'h20,
    st_sleep       = 8'h40,
    st_deep_sleep  = 8'h80
  } trx_state_t;
endpackage : sleep_pkg

/* logic/sleep_tx_pin_control.sv */
// sleep/transmit pin state control with gated clock output
`timescale 1ns/1ps
`default_nettype none
module sleep_tx_pin_control (
  input  wire logic                        mclk_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        sleep_tx_pin_i,
  input  wire logic                        cmd_valid_i,
  input  wire sleep_pkg::trx_state_t       cmd_state_i,
  input  wire logic                        slotted_i,
  input  wire logic                        rate_wr_i,
  input  wire logic [sleep_pkg::RATE_W-1:0] rate_i,
  output logic                             clock_out_pin_o,
  output sleep_pkg::trx_state_t            state_o,
  output logic                             tx_start_o,
  output logic                             aret_start_o,
  output logic                             ack_start_o,
  output logic                             wake_done_o,
  output logic [sleep_pkg::RATE_W-1:0]     rate_o,
  output logic                             reg_clear_o
);
  import sleep_pkg::*;

  // --------------------------------------------------------------
  // reset release and pin synchroniser
  // --------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic rise;
  logic fall;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // whole chain starts high so a pin already high at reset is no edge
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= sleep_tx_pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign rise = pin_sync_reg & ~pin_prev_reg;
  assign fall = ~pin_sync_reg & pin_prev_reg;

  // --------------------------------------------------------------
  // transceiver state
  // --------------------------------------------------------------
  trx_state_t state_reg;
  logic       asleep;
  logic       wake;
  logic       enter_sleep;
  logic       enter_deep;

  assign asleep      = (state_reg == st_sleep) || (state_reg == st_deep_sleep);
  assign wake        = asleep && !pin_sync_reg;
  assign enter_sleep = (state_reg == st_idle) && rise;
  assign enter_deep  = (state_reg == st_deep_prep) && rise;

  // pin wins over a core command in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_idle;
    end else if (enter_sleep) begin
      state_reg <= st_sleep;
    end else if (enter_deep) begin
      state_reg <= st_deep_sleep;
    end else if (wake) begin
      state_reg <= st_idle;
    end else if (cmd_valid_i && !asleep) begin
      state_reg <= cmd_state_i;
    end
  end

  // --------------------------------------------------------------
  // transmit triggers
  // --------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_start_o   <= 1'b0;
      aret_start_o <= 1'b0;
      ack_start_o  <= 1'b0;
    end else begin
      tx_start_o   <= rise && (state_reg == st_synth_ready);
      aret_start_o <= rise && (state_reg == st_auto_retry);
      ack_start_o  <= rise && (state_reg == st_busy_aack) && slotted_i;
    end
  end

  // --------------------------------------------------------------
  // wake-done event and register clear
  // --------------------------------------------------------------
  logic boot_reg;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg    <= 1'b1;
      wake_done_o <= 1'b0;
      reg_clear_o <= 1'b0;
      state_o     <= st_idle;
    end else begin
      boot_reg    <= 1'b0;
      wake_done_o <= boot_reg || wake;
      reg_clear_o <= enter_deep || ((state_reg == st_deep_sleep) && !wake);
      state_o     <= state_reg;
    end
  end

  // --------------------------------------------------------------
  // clock output rate setting
  // --------------------------------------------------------------
  logic [RATE_W-1:0] rate_reg;
  logic              slow_rate;

  assign slow_rate = (rate_reg == RATE_250K) || (rate_reg == RATE_62K5);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rate_reg <= RATE_RESET;
    end else if (state_reg == st_deep_sleep) begin
      rate_reg <= RATE_RESET;
    end else if (rate_wr_i) begin
      rate_reg <= rate_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rate_o <= RATE_RESET;
    end else begin
      rate_o <= rate_reg;
    end
  end

  // --------------------------------------------------------------
  // clock output divider and stop logic
  // --------------------------------------------------------------
  function automatic logic [DIV_W-1:0] half_of(input logic [RATE_W-1:0] r);
    case (r)
      RATE_2M:   half_of = HALF_2M;
      RATE_4M:   half_of = HALF_4M;
      RATE_250K: half_of = HALF_250K;
      RATE_62K5: half_of = HALF_62K5;
      default:   half_of = HALF_1M;
    endcase
  endfunction : half_of

  logic [DIV_W-1:0] div_reg;
  logic [5:0]       drain_reg;
  logic             clk_reg;
  logic             tick;
  logic             run;

  // a rate change mid-phase ends that phase early rather than wrapping the divider
  assign tick = (div_reg >= half_of(rate_reg) - 9'h001);
  // the host may be clocked from this pin, so it needs time to park
  assign run  = (rate_reg != RATE_OFF) && (!asleep || drain_reg != 6'h00);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      drain_reg <= 6'h00;
    end else if (enter_sleep || enter_deep) begin
      drain_reg <= slow_rate ? 6'h00 : DRAIN_RELOAD;
    end else if (!asleep) begin
      drain_reg <= 6'h00;
    end else if (drain_reg != 6'h00 && tick && clk_reg) begin
      drain_reg <= drain_reg - 6'h01;
    end
  end

  // drained stop lands on a low phase, no runt pulse; a slow-rate stop forces the output low at once
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      clk_reg <= 1'b0;
    end else if ((enter_sleep || enter_deep) && slow_rate) begin
      div_reg <= '0;
      clk_reg <= 1'b0;
    end else if (!run) begin
      div_reg <= '0;
      clk_reg <= 1'b0;
    end else if (tick) begin
      div_reg <= '0;
      clk_reg <= ~clk_reg;
    end else begin
      div_reg <= div_reg + 9'h001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      clock_out_pin_o <= 1'b0;
    end else begin
      clock_out_pin_o <= clk_reg;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  a_tx_on_rise: assert property (
    rise && state_reg == st_synth_ready |=> tx_start_o && !aret_start_o)
    else $error("no frame start after rising edge");

  a_aret_on_rise: assert property (
    rise && state_reg == st_auto_retry |=> aret_start_o && !tx_start_o)
    else $error("no retry start after rising edge");

  a_no_fall_start: assert property (
    !rise |=> !tx_start_o && !aret_start_o && !ack_start_o)
    else $error("transmit start without rising edge");

  a_ack_slotted: assert property (
    rise && state_reg == st_busy_aack && slotted_i |=> ack_start_o)
    else $error("no ack start in slotted receive");

  a_sleep_entry: assert property (
    enter_sleep |=> state_reg == st_sleep ##1 state_o == st_sleep)
    else $error("sleep not entered");

  a_deep_entry: assert property (
    enter_deep |=> state_reg == st_deep_sleep && reg_clear_o)
    else $error("deep sleep not entered");

  a_wake_level: assert property (
    asleep && !pin_sync_reg |=> state_reg == st_idle && wake_done_o)
    else $error("no wake on low level");

  a_stay_asleep: assert property (
    asleep && pin_sync_reg |=> asleep)
    else $error("left sleep while pin high");

  a_drain_load: assert property (
    enter_sleep && !slow_rate && rate_reg != RATE_OFF
      |=> drain_reg == DRAIN_RELOAD && run)
    else $error("clock drain not armed");

  a_slow_stop: assert property (
    (enter_sleep || enter_deep) && slow_rate |=> !clk_reg ##1 !clock_out_pin_o)
    else $error("slow clock not stopped at once");

  a_rate_reset: assert property (
    state_reg == st_deep_sleep && wake |=> rate_reg == RATE_RESET ##1 rate_o == RATE_RESET)
    else $error("rate not reset after deep sleep");

  a_stopped_low: assert property (
    asleep && drain_reg == 6'h00 && !$past(run) |-> !clk_reg)
    else $error("clock output runs while stopped");

  a_other_hold: assert property (
    state_reg == st_other && !cmd_valid_i |=> state_reg == st_other)
    else $error("state moved in other state");

  a_fall_wake: assert property (
    asleep && fall |=> state_reg == st_idle)
    else $error("no return to idle on falling edge");

  a_deep_clear: assert property (
    state_reg == st_deep_sleep && !wake |=> reg_clear_o)
    else $error("registers not held clear in deep sleep");

  a_clear_off: assert property (
    state_reg != st_deep_sleep && !enter_deep |=> !reg_clear_o)
    else $error("register clear outside deep sleep");

  a_deep_rate_hold: assert property (
    state_reg == st_deep_sleep |=> rate_reg == RATE_RESET)
    else $error("rate not held at reset value in deep sleep");

  a_wake_pulse: assert property (
    !boot_reg && !wake |=> !wake_done_o)
    else $error("wake-done without wake");

  a_drain_step: assert property (
    asleep && drain_reg != 6'h00 && tick && clk_reg
      |=> drain_reg == $past(drain_reg) - 6'h01 && !clk_reg)
    else $error("drain count not stepped on clock fall");

  a_cmd_take: assert property (
    cmd_valid_i && !asleep && !enter_sleep && !enter_deep
      |=> state_reg == $past(cmd_state_i))
    else $error("core state command not taken");

  c_ack_start: cover property (ack_start_o);
  c_sleep_cycle: cover property (enter_sleep ##[1:200] wake);
  c_deep_cycle: cover property (enter_deep ##[1:200] wake);
  c_tx_start: cover property (tx_start_o);
  c_drain_done: cover property (asleep && $fell(run));

endmodule : sleep_tx_pin_control
`default_nettype wire

/* sim/host_pin_model.sv */
// host side model that drives the sleep/transmit pin
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
  input  wire logic mclk_i,
  output var  logic sleep_tx_pin_o
);
  // host runs from the controller's mclk_i, never from the slow output rates
  initial sleep_tx_pin_o = 1'b0;

  // high to sleep, released low to wake; moved only after a falling edge
  task automatic set_pin(input logic level);
    @(negedge mclk_i);
    sleep_tx_pin_o = level;
  endtask : set_pin
endmodule : host_pin_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the sleep/transmit pin controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sleep_pkg::*;
  logic              mclk_i      = 1'b0;
  logic              reset_n_i   = 1'b0;
  logic              cmd_valid_i = 1'b0;
  trx_state_t        cmd_state_i = st_idle;
  logic              slotted_i   = 1'b0;
  logic              rate_wr_i   = 1'b0;
  logic [RATE_W-1:0] rate_i      = RATE_1M;
  logic              pin, clk_out, tx_s, aret_s, ack_s, wake, rclr;
  logic              clk_prev    = 1'b0;
  trx_state_t        state_o;
  logic [RATE_W-1:0] rate_o;
  int num_errors = 0, check_count = 0;
  int n_tx = 0, n_aret = 0, n_ack = 0, n_wake = 0, n_fall = 0;

  always #12.5 mclk_i = ~mclk_i;

  host_pin_model host_pin_model_inst (.mclk_i(mclk_i), .sleep_tx_pin_o(pin));

  sleep_tx_pin_control sleep_tx_pin_control_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sleep_tx_pin_i(pin),
    .cmd_valid_i(cmd_valid_i), .cmd_state_i(cmd_state_i), .slotted_i(slotted_i),
    .rate_wr_i(rate_wr_i), .rate_i(rate_i), .clock_out_pin_o(clk_out),
    .state_o(state_o), .tx_start_o(tx_s), .aret_start_o(aret_s),
    .ack_start_o(ack_s), .wake_done_o(wake), .rate_o(rate_o), .reg_clear_o(rclr)
  );

  // pulses counted as they occur, so scenarios compare count deltas
  always @(posedge mclk_i) begin
    n_tx     <= n_tx + int'(tx_s === 1'b1);
    n_aret   <= n_aret + int'(aret_s === 1'b1);
    n_ack    <= n_ack + int'(ack_s === 1'b1);
    n_wake   <= n_wake + int'(wake === 1'b1);
    n_fall   <= n_fall + int'(clk_prev === 1'b1 && clk_out === 1'b0);
    clk_prev <= clk_out;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic cmd(input trx_state_t s);
    @(negedge mclk_i);
    cmd_valid_i = 1'b1;
    cmd_state_i = s;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : cmd

  task automatic set_rate(input logic [RATE_W-1:0] r);
    @(negedge mclk_i);
    rate_wr_i = 1'b1;
    rate_i    = r;
    @(negedge mclk_i);
    rate_wr_i = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : set_rate

  // pin levels held well beyond the 3-cycle minimum
  task automatic pin_to(input logic v);
    host_pin_model_inst.set_pin(v);
    repeat (8) @(negedge mclk_i);
  endtask : pin_to

  task automatic t_reset();
    check(state_o, st_idle);
    check(8'(rate_o), 8'(RATE_1M));
    check(8'(n_wake), 8'h01);
  endtask : t_reset

  task automatic t_trigger();
    int a;
    int b;
    cmd(st_synth_ready);
    a = n_tx;
    pin_to(1'b1);
    check(8'(n_tx - a), 8'h01);
    pin_to(1'b0);
    check(8'(n_tx - a), 8'h01);
    cmd(st_auto_retry);
    b = n_aret;
    pin_to(1'b1);
    pin_to(1'b0);
    check(8'(n_aret - b), 8'h01);
  endtask : t_trigger

  task automatic t_ack();
    int a;
    cmd(st_busy_aack);
    a = n_ack;
    pin_to(1'b1);
    pin_to(1'b0);
    check(8'(n_ack - a), 8'h00);
    slotted_i = 1'b1;
    pin_to(1'b1);
    pin_to(1'b0);
    check(8'(n_ack - a), 8'h01);
    slotted_i = 1'b0;
  endtask : t_ack

  task automatic t_other();
    int a;
    cmd(st_other);
    a = n_tx + n_aret + n_ack;
    pin_to(1'b1);
    pin_to(1'b0);
    check(state_o, st_other);
    check(8'(n_tx + n_aret + n_ack - a), 8'h00);
  endtask : t_other

  // sleep entry from idle, then clock drain count, then wake on low level
  task automatic t_sleep(input logic [RATE_W-1:0] r, input int lo, input int hi, input int span);
    int f;
    int w;
    int d;
    cmd(st_idle);
    set_rate(r);
    pin_to(1'b1);
    check(state_o, st_sleep);
    f = n_fall;
    repeat (span) @(negedge mclk_i);
    d = n_fall - f;
    check(8'(d >= lo && d <= hi), 8'h01);
    check(8'(clk_out), 8'h00);
    check(state_o, st_sleep);
    w = n_wake;
    pin_to(1'b0);
    check(state_o, st_idle);
    check(8'(n_wake - w), 8'h01);
  endtask : t_sleep

  task automatic t_deep();
    cmd(st_deep_prep);
    set_rate(RATE_2M);
    pin_to(1'b1);
    check(state_o, st_deep_sleep);
    check(8'(rclr), 8'h01);
    set_rate(RATE_250K);
    check(8'(rate_o), 8'(RATE_1M));
    pin_to(1'b0);
    check(state_o, st_idle);
    check(8'(rate_o), 8'(RATE_1M));
    check(8'(rclr), 8'h00);
  endtask : t_deep

  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // whole run is near 3700 cycles; cut off at over five times that
  initial begin
    #(25 * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(negedge mclk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    t_reset();
    t_trigger();
    t_ack();
    t_other();
    t_sleep(RATE_1M, 34, 35, 1500);
    t_sleep(RATE_4M, 34, 35, 400);
    t_sleep(RATE_250K, 0, 0, 700);
    t_sleep(RATE_62K5, 0, 0, 700);
    t_sleep(RATE_OFF, 0, 0, 100);
    t_deep();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
